// file: pcb_bist_ctrl.sv
// Top of the protector comparator self-test controller: registers,
// fault flags, interrupt, voltage, temperature and balance-done groups.
// Assumes synchronous analog comparator inputs and a 100 MHz clock.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "pcb_params.svh"
module pcb_bist_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic ov_trip,
  input wire logic uv_trip,
  input wire logic ot_trip,
  input wire logic ut_trip,
  input wire logic balance_done_comparator,
  output logic [2:0] volt_channel,
  output logic [2:0] temp_channel,
  output logic [7:0] volt_diag_dac,
  output logic [7:0] temp_diag_dac,
  output logic volt_test_active,
  output logic temp_test_active,
  output logic volt_cmp_mask,
  output logic temp_cmp_mask,
  output logic thermistor_reference,
  output logic irq
);
  logic rst_q1;
  logic rst_n;
  pcb_pkg::pcb_req_t req;
  logic [3:0] diagnostic_control_one;
  logic [2:0] main_control_two;
  logic [5:0] voltage_channel_enables;
  logic [5:0] temp_channel_enables;
  logic [3:0] aux_converter_control_two;
  logic [15:0] thresholds;
  logic [1:0] voltage_selftest_fault_reg;
  logic [1:0] temp_selftest_fault_reg;
  logic system_fault_third;
  logic [1:0] loop_stat;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic [3:0] next_diag;
  logic [2:0] next_ctrl;
  logic [5:0] next_vch;
  logic [5:0] next_tch;
  logic [3:0] next_aux;
  logic [15:0] next_thr;
  logic [1:0] next_vflt;
  logic [1:0] next_tflt;
  logic next_sysf3;
  logic [1:0] next_loop;
  logic [4:0] next_irq_stat;
  logic [4:0] next_irq_mask;
  logic [31:0] next_rdata;
  pcb_pkg::pcb_cfg_t vcfg;
  pcb_pkg::pcb_cfg_t tcfg;
  pcb_pkg::pcb_cmp_t vcmp;
  pcb_pkg::pcb_cmp_t tcmp;
  pcb_pkg::pcb_cmp_t bcmp;
  pcb_pkg::pcb_state_t vstate;
  pcb_pkg::pcb_state_t tstate;
  logic [1:0] loop_ev;
  logic v_hi_f, v_lo_f, t_hi_f, t_lo_f, b_f, b_unused;
  logic [4:0] irq_ev;

  // Hit test used by both write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign thermistor_reference = main_control_two[`PCB_THERMISTOR_REFERENCE_BIT];

  // Group configurations offered at the enable edge
  assign vcfg = '{mode: diagnostic_control_one[`PCB_VMODE_LSB +: 2],
                  chans: voltage_channel_enables,
                  dac_meas: |aux_converter_control_two[1:0]};
  assign tcfg = '{mode: diagnostic_control_one[`PCB_TMODE_LSB +: 2],
                  chans: temp_channel_enables,
                  dac_meas: |aux_converter_control_two[3:2]};
  assign vcmp = '{high_trip: ov_trip, low_trip: uv_trip};
  assign tcmp = '{high_trip: ot_trip, low_trip: ut_trip};
  // Balance-done shares the voltage sequencing
  assign bcmp = '{high_trip: balance_done_comparator, low_trip: 1'b0};

  pcb_group u_volt (
    .clock(clock),
    .rst_n(rst_n),
    .enable(main_control_two[`PCB_VEN_BIT]),
    .cfg_in(vcfg),
    .cmp(vcmp),
    .threshold(thresholds[7:0]),
    .channel(volt_channel),
    .test_active(volt_test_active),
    .diag_dac(volt_diag_dac),
    .mask_out(volt_cmp_mask),
    .loop_done(loop_ev[0]),
    .high_fail(v_hi_f),
    .low_fail(v_lo_f),
    .state(vstate)
  );
  pcb_group u_temp (
    .clock(clock),
    .rst_n(rst_n),
    .enable(main_control_two[`PCB_TEN_BIT]),
    .cfg_in(tcfg),
    .cmp(tcmp),
    .threshold(thresholds[15:8]),
    .channel(temp_channel),
    .test_active(temp_test_active),
    .diag_dac(temp_diag_dac),
    .mask_out(temp_cmp_mask),
    .loop_done(loop_ev[1]),
    .high_fail(t_hi_f),
    .low_fail(t_lo_f),
    .state(tstate)
  );
  pcb_group u_bdone (
    .clock(clock),
    .rst_n(rst_n),
    .enable(main_control_two[`PCB_VEN_BIT]),
    .cfg_in(vcfg),
    .cmp(bcmp),
    .threshold(thresholds[7:0]),
    .channel(),
    .test_active(),
    .diag_dac(),
    .mask_out(),
    .loop_done(),
    .high_fail(b_f),
    .low_fail(b_unused),
    .state()
  );

  assign irq_ev = {b_f, t_hi_f | t_lo_f, v_hi_f | v_lo_f, loop_ev};

  // Register writes, sticky flags, read data
  always_comb begin
    next_diag = diagnostic_control_one;
    next_ctrl = main_control_two;
    next_vch = voltage_channel_enables;
    next_tch = temp_channel_enables;
    next_aux = aux_converter_control_two;
    next_thr = thresholds;
    next_irq_mask = irq_mask;
    next_vflt = voltage_selftest_fault_reg;
    next_tflt = temp_selftest_fault_reg;
    next_sysf3 = system_fault_third;
    next_loop = loop_stat;
    next_irq_stat = irq_stat;
    next_rdata = 32'h0000_0000;
    if (req.wr) begin
      if (hit(req.addr, `PCB_DIAG_ONE_ADDR)) next_diag = req.wdata[3:0];
      if (hit(req.addr, `PCB_CTRL_TWO_ADDR)) next_ctrl = req.wdata[2:0];
      if (hit(req.addr, `PCB_VCH_EN_ADDR)) next_vch = req.wdata[5:0];
      if (hit(req.addr, `PCB_TCH_EN_ADDR)) next_tch = req.wdata[5:0];
      if (hit(req.addr, `PCB_AUX_TWO_ADDR)) next_aux = req.wdata[3:0];
      if (hit(req.addr, `PCB_THR_ADDR)) next_thr = req.wdata[15:0];
      if (hit(req.addr, `PCB_IRQ_MSK_ADDR)) next_irq_mask = req.wdata[4:0];
      // Write one to clear fault flags
      if (hit(req.addr, `PCB_VFLT_ADDR)) next_vflt = next_vflt & ~req.wdata[1:0];
      if (hit(req.addr, `PCB_TFLT_ADDR)) next_tflt = next_tflt & ~req.wdata[1:0];
      if (hit(req.addr, `PCB_SYSF3_ADDR)) next_sysf3 = next_sysf3 & ~req.wdata[0];
      if (hit(req.addr, `PCB_IRQ_ST_ADDR)) next_irq_stat = irq_stat & ~req.wdata[4:0];
    end
    if (req.rd) begin
      if (hit(req.addr, `PCB_DIAG_ONE_ADDR)) next_rdata[3:0] = diagnostic_control_one;
      if (hit(req.addr, `PCB_CTRL_TWO_ADDR)) next_rdata[2:0] = main_control_two;
      if (hit(req.addr, `PCB_VCH_EN_ADDR)) next_rdata[5:0] = voltage_channel_enables;
      if (hit(req.addr, `PCB_TCH_EN_ADDR)) next_rdata[5:0] = temp_channel_enables;
      if (hit(req.addr, `PCB_AUX_TWO_ADDR)) next_rdata[3:0] = aux_converter_control_two;
      if (hit(req.addr, `PCB_VFLT_ADDR)) next_rdata[1:0] = voltage_selftest_fault_reg;
      if (hit(req.addr, `PCB_TFLT_ADDR)) next_rdata[1:0] = temp_selftest_fault_reg;
      if (hit(req.addr, `PCB_SYSF3_ADDR)) next_rdata[0] = system_fault_third;
      if (hit(req.addr, `PCB_IRQ_ST_ADDR)) next_rdata[4:0] = irq_stat;
      if (hit(req.addr, `PCB_IRQ_MSK_ADDR)) next_rdata[4:0] = irq_mask;
      if (hit(req.addr, `PCB_STATE_ADDR)) next_rdata[5:0] = {vstate, tstate};
      if (hit(req.addr, `PCB_THR_ADDR)) next_rdata[15:0] = thresholds;
      if (hit(req.addr, `PCB_LOOP_ADDR)) begin
        next_rdata[1:0] = loop_stat;
        next_loop = 2'h0; // Cleared by the read
      end
    end
    // Hardware sets win over software clears
    next_vflt = next_vflt | {v_hi_f, v_lo_f};
    next_tflt = next_tflt | {t_hi_f, t_lo_f};
    next_sysf3 = next_sysf3 | b_f;
    next_loop = next_loop | loop_ev;
    next_irq_stat = next_irq_stat | irq_ev;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diagnostic_control_one <= {`PCB_MODE_RST, `PCB_MODE_RST};
      main_control_two <= 3'h0;
      voltage_channel_enables <= `PCB_CH_RST;
      temp_channel_enables <= `PCB_CH_RST;
      aux_converter_control_two <= 4'h0;
      thresholds <= {`PCB_THR_RST, `PCB_THR_RST};
      voltage_selftest_fault_reg <= 2'h0;
      temp_selftest_fault_reg <= 2'h0;
      system_fault_third <= 1'b0;
      loop_stat <= 2'h0;
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
      rdata <= 32'h0000_0000;
    end else begin
      diagnostic_control_one <= next_diag;
      main_control_two <= next_ctrl;
      voltage_channel_enables <= next_vch;
      temp_channel_enables <= next_tch;
      aux_converter_control_two <= next_aux;
      thresholds <= next_thr;
      voltage_selftest_fault_reg <= next_vflt;
      temp_selftest_fault_reg <= next_tflt;
      system_fault_third <= next_sysf3;
      loop_stat <= next_loop;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
    end
  end

  // Level interrupt from unmasked sticky events
  assign irq = |(irq_stat & irq_mask);
endmodule // pcb_bist_ctrl
`default_nettype wire

// file: pcb_bist_ctrl_asserts.sv
// Port checker for the comparator self-test controller.
// Assumes a bind to pcb_bist_ctrl and its one clock domain.
`timescale 1ns/1ns
`default_nettype none
module pcb_bist_ctrl_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [2:0] volt_channel,
  input wire logic [2:0] temp_channel,
  input wire logic [7:0] volt_diag_dac,
  input wire logic [7:0] temp_diag_dac,
  input wire logic volt_test_active,
  input wire logic temp_test_active,
  input wire logic volt_cmp_mask,
  input wire logic temp_cmp_mask
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // DAC moves inside a running test slot
  sequence s_vmove;
    volt_test_active && $past(volt_test_active) && $changed(volt_diag_dac);
  endsequence
  sequence s_tmove;
    temp_test_active && $past(temp_test_active) && $changed(temp_diag_dac);
  endsequence
  // Read data only in the cycle after a read
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero without a read");
  a_vstep_four: assert property (s_vmove |->
    volt_diag_dac == $past(volt_diag_dac) + 8'h04)
    else $error("voltage diagnostic step wrong");
  a_tstep_four: assert property (s_tmove |->
    temp_diag_dac == $past(temp_diag_dac) + 8'h04)
    else $error("temperature diagnostic step wrong");
  // Low step lasts one slot before the high step
  a_vlow_slot: assert property ($rose(volt_test_active) |->
    ##[99:101] $changed(volt_diag_dac))
    else $error("voltage low step length wrong");
  a_tlow_slot: assert property ($rose(temp_test_active) |->
    ##[99:101] $changed(temp_diag_dac))
    else $error("temperature low step length wrong");
  a_vmask_notest: assert property (volt_cmp_mask |-> !volt_test_active)
    else $error("voltage self test while masked");
  a_tmask_notest: assert property (temp_cmp_mask |-> !temp_test_active)
    else $error("temperature self test while masked");
  // Single mode keeps its channel while masked
  a_vmask_hold: assert property (
    volt_cmp_mask && $past(volt_cmp_mask) |-> $stable(volt_channel))
    else $error("voltage channel moved in single mode");
  a_tmask_hold: assert property (
    temp_cmp_mask && $past(temp_cmp_mask) |-> $stable(temp_channel))
    else $error("temperature channel moved in single mode");
  a_vchan_range: assert property (volt_channel <= 3'h5)
    else $error("voltage channel out of range");
  a_tchan_range: assert property (temp_channel <= 3'h5)
    else $error("temperature channel out of range");
endmodule // pcb_bist_ctrl_asserts
`default_nettype wire

// file: pcb_bist_ctrl_tb.sv
// Self-checking bench for the comparator self-test controller.
// Assumes a 100 MHz clock; the bench plays all analog comparators.
`timescale 1ns/1ns
`default_nettype none
module pcb_bist_ctrl_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ov_trip = 1'b0;
  logic uv_trip = 1'b0;
  logic ot_trip = 1'b0;
  logic ut_trip = 1'b0;
  logic balance_done_comparator = 1'b0;
  logic stuck = 1'b0;
  logic [31:0] rdata;
  logic [2:0] volt_channel, temp_channel;
  logic [7:0] volt_diag_dac, temp_diag_dac;
  logic volt_test_active, temp_test_active, volt_cmp_mask;
  logic temp_cmp_mask, thermistor_reference, irq;
  int fail_count = 0;
  int n_compared = 0;
  // Clock
  always #5 clock = ~clock;
  // Comparators follow the DACs against the reset threshold
  always @(posedge clock) begin
    ov_trip <= !stuck && (volt_diag_dac > 8'h80);
    uv_trip <= !stuck && (volt_diag_dac < 8'h80);
    balance_done_comparator <= !stuck && (volt_diag_dac > 8'h80);
    ot_trip <= temp_diag_dac > 8'h80;
    ut_trip <= temp_diag_dac < 8'h80;
  end
  pcb_bist_ctrl pcb_bist_ctrl_i (.clock(clock), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ov_trip(ov_trip),
    .uv_trip(uv_trip), .ot_trip(ot_trip), .ut_trip(ut_trip),
    .balance_done_comparator(balance_done_comparator),
    .volt_channel(volt_channel), .temp_channel(temp_channel),
    .volt_diag_dac(volt_diag_dac), .temp_diag_dac(temp_diag_dac),
    .volt_test_active(volt_test_active), .temp_test_active(temp_test_active),
    .volt_cmp_mask(volt_cmp_mask), .temp_cmp_mask(temp_cmp_mask),
    .thermistor_reference(thermistor_reference), .irq(irq));
  // Verdict
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Register bus cycles
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // Bounded wait for a group's test flag
  task automatic wait_test(input bit t, input bit lvl);
    int n;
    n = 0;
    while ((t ? temp_test_active : volt_test_active) !== lvl && n < 1000) begin
      idle(1);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic t_reset;
    rchk(8'h30, 32'h00008080);
    rchk(8'h20, 32'h0);
    wreg(8'h3C, 32'hFFFFFFFF);
    rchk(8'h3C, 32'h0);
    $display("reset and unmapped test done");
  endtask
  task automatic t_vtest;
    wreg(8'h08, 32'h01);
    wreg(8'h04, 32'h01);
    idle(110);
    rchk(8'h20, 32'h1);
    rchk(8'h20, 32'h0);
    wait_test(0, 1);
    rchk(8'h20, 32'h0);
    idle(50);
    check(volt_diag_dac, 8'h7E);
    idle(100);
    check(volt_diag_dac, 8'h82);
    wait_test(0, 0);
    idle(3);
    rchk(8'h14, 32'h0);
    rchk(8'h1C, 32'h0);
    wreg(8'h04, 32'h0);
    $display("voltage self test done");
  endtask
  task automatic t_fault;
    stuck <= 1'b1;
    wreg(8'h24, 32'h1F);
    wreg(8'h04, 32'h01);
    wait_test(0, 1);
    wait_test(0, 0);
    idle(3);
    rchk(8'h14, 32'h3);
    rchk(8'h1C, 32'h1);
    check(irq, 1'b0);
    wreg(8'h28, 32'h04);
    idle(1);
    check(irq, 1'b1);
    wreg(8'h04, 32'h0);
    stuck <= 1'b0;
    wreg(8'h14, 32'h3);
    wreg(8'h1C, 32'h1);
    wreg(8'h24, 32'h1F);
    idle(1);
    check(irq, 1'b0);
    rchk(8'h14, 32'h0);
    $display("stuck comparator test done");
  endtask
  task automatic t_temp;
    logic bad;
    bad = 1'b0;
    wreg(8'h00, 32'h4);
    wreg(8'h0C, 32'h06);
    wreg(8'h04, 32'h02);
    repeat (450) begin
      idle(1);
      if (temp_test_active !== 1'b0 ||
          (temp_channel !== 3'h1 && temp_channel !== 3'h2))
        bad = 1'b1;
    end
    check(bad, 1'b0);
    wreg(8'h04, 32'h0);
    wreg(8'h00, 32'h0);
    wreg(8'h04, 32'h02);
    wait_test(1, 1);
    check(temp_diag_dac, 8'h7E);
    wait_test(1, 0);
    idle(3);
    rchk(8'h18, 32'h0);
    wreg(8'h04, 32'h0);
    $display("temperature test done");
  endtask
  task automatic t_single;
    logic bad;
    bad = 1'b0;
    wreg(8'h10, 32'h1);
    wreg(8'h00, 32'h2);
    wreg(8'h08, 32'h0C);
    wreg(8'h04, 32'h01);
    idle(3);
    check(volt_cmp_mask, 1'b1);
    repeat (400) begin
      idle(1);
      if (volt_test_active !== 1'b0 || volt_channel !== 3'h2)
        bad = 1'b1;
    end
    check(bad, 1'b0);
    wreg(8'h00, 32'h0);
    wreg(8'h08, 32'h01);
    idle(3);
    check(volt_channel, 3'h2);
    check(volt_cmp_mask, 1'b1);
    wreg(8'h00, 32'h3);
    wreg(8'h10, 32'h0);
    wreg(8'h04, 32'h0);
    wreg(8'h04, 32'h01);
    idle(3);
    check(volt_cmp_mask, 1'b0);
    check(volt_channel, 3'h0);
    // Temperature DAC measurement setup, reference after enable
    wreg(8'h10, 32'h8);
    wreg(8'h00, 32'h8);
    wreg(8'h04, 32'h03);
    wreg(8'h04, 32'h07);
    idle(3);
    check(temp_cmp_mask, 1'b1);
    check(temp_channel, 3'h1);
    check(thermistor_reference, 1'b1);
    check(temp_test_active, 1'b0);
    wreg(8'h04, 32'h0);
    wreg(8'h00, 32'h0);
    $display("single channel test done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    check(volt_diag_dac, 8'h80);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_vtest();
    t_fault();
    t_temp();
    t_single();
    report_and_stop();
  end
endmodule // pcb_bist_ctrl_tb
bind pcb_bist_ctrl pcb_bist_ctrl_asserts pcb_bist_ctrl_asserts_i (
  .clock(clock), .nrst(nrst), .rd(rd), .rdata(rdata),
  .volt_channel(volt_channel), .temp_channel(temp_channel),
  .volt_diag_dac(volt_diag_dac), .temp_diag_dac(temp_diag_dac),
  .volt_test_active(volt_test_active), .temp_test_active(temp_test_active),
  .volt_cmp_mask(volt_cmp_mask), .temp_cmp_mask(temp_cmp_mask));
`default_nettype wire

// file: pcb_deglitch.sv
// Self-test deglitch: a sample counts as switched only after it held
// steady for the self-test deglitch interval.
// Assumes synchronous inputs and the synchronised reset of the top.
`timescale 1ns/1ns
`default_nettype none
`include "pcb_params.svh"
module pcb_deglitch (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic raw,
  output logic stable
);
  localparam int unsigned DGW = 8;
  localparam logic [DGW-1:0] DG_MAX = DGW'(`PCB_DG_CYC);
  logic [DGW-1:0] cnt;
  logic [DGW-1:0] next_cnt;
  logic last;
  logic next_last;
  logic next_stable;

  // Restart on change, settle after the full interval
  always_comb begin
    next_last = raw;
    next_cnt = cnt;
    next_stable = stable;
    if (clear || raw != last) begin
      next_cnt = '0;
      next_stable = 1'b0;
    end else if (cnt != DG_MAX) begin
      next_cnt = cnt + DGW'(1);
    end else begin
      next_stable = raw;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      last <= 1'b0;
      stable <= 1'b0;
    end else begin
      cnt <= next_cnt;
      last <= next_last;
      stable <= next_stable;
    end
  end
endmodule // pcb_deglitch
`default_nettype wire

// file: pcb_group.sv
// One comparator group: round robin, self-test slots, single channel.
// Assumes the comparator pair follows the channel and DAC it is given.
`timescale 1ns/1ns
`default_nettype none
`include "pcb_params.svh"
module pcb_group (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire pcb_pkg::pcb_cfg_t cfg_in,
  input wire pcb_pkg::pcb_cmp_t cmp,
  input wire logic [7:0] threshold,
  output logic [2:0] channel,
  output logic test_active,
  output logic [7:0] diag_dac,
  output logic mask_out,
  output logic loop_done,
  output logic high_fail,
  output logic low_fail,
  output var pcb_pkg::pcb_state_t state
);
  localparam logic [15:0] SLOT = 16'(`PCB_SLOT_CYC);
  pcb_pkg::pcb_cfg_t cfg;
  pcb_pkg::pcb_cfg_t next_cfg;
  pcb_pkg::pcb_state_t next_state;
  logic en_d;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic [2:0] next_channel;
  logic test_turn;
  logic next_test_turn;
  logic hi_low_seen;
  logic lo_low_seen;
  logic next_hi_low_seen;
  logic next_lo_low_seen;
  logic hi_s;
  logic lo_s;
  logic dg_clear;
  logic rise;

  // Lowest enabled channel
  function automatic logic [2:0] first_ch(input logic [5:0] en);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (en[i]) r = 3'(i);
    end
    return r;
  endfunction

  // Next enabled channel after cur, wrap flagged by 3'h7
  function automatic logic [2:0] next_ch(input logic [5:0] en,
                                         input logic [2:0] cur);
    logic [2:0] r;
    r = 3'h7;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && 3'(i) > cur) r = 3'(i);
    end
    return r;
  endfunction

  assign rise = enable && !en_d;
  assign dg_clear = (state != pcb_pkg::PCB_T_LOW) &&
                    (state != pcb_pkg::PCB_T_HIGH);

  // Both comparator outputs deglitched before judging
  pcb_deglitch u_dg_hi (
    .clock(clock),
    .rst_n(rst_n),
    .clear(dg_clear),
    .raw(cmp.high_trip),
    .stable(hi_s)
  );
  pcb_deglitch u_dg_lo (
    .clock(clock),
    .rst_n(rst_n),
    .clear(dg_clear),
    .raw(cmp.low_trip),
    .stable(lo_s)
  );

  // Diagnostic DAC two steps below then above threshold
  always_comb begin
    diag_dac = threshold;
    if (state == pcb_pkg::PCB_T_LOW) diag_dac = threshold - `PCB_DIAG_STEP;
    if (state == pcb_pkg::PCB_T_HIGH) diag_dac = threshold + `PCB_DIAG_STEP;
  end
  assign test_active = (state == pcb_pkg::PCB_T_LOW) ||
                       (state == pcb_pkg::PCB_T_HIGH);
  // Masked in single mode entered with DAC path on
  assign mask_out = (state == pcb_pkg::PCB_HOLD) && cfg.dac_meas;

  // Sequencer next state
  always_comb begin
    next_cfg = cfg;
    next_state = state;
    next_tmr = tmr;
    next_channel = channel;
    next_test_turn = test_turn;
    next_hi_low_seen = hi_low_seen;
    next_lo_low_seen = lo_low_seen;
    loop_done = 1'b0;
    high_fail = 1'b0;
    low_fail = 1'b0;
    if (!enable) begin
      next_state = pcb_pkg::PCB_IDLE;
    end else if (rise) begin
      next_cfg = cfg_in; // Latched on enable edge only
      next_channel = first_ch(cfg_in.chans);
      next_tmr = '0;
      next_test_turn = 1'b0;
      if (cfg_in.mode[1]) next_state = pcb_pkg::PCB_HOLD;
      else next_state = pcb_pkg::PCB_SCAN;
    end else begin
      unique case (state)
        pcb_pkg::PCB_IDLE: next_state = pcb_pkg::PCB_IDLE;
        // Fixed channel, no stepping, no self
        pcb_pkg::PCB_HOLD: next_state = pcb_pkg::PCB_HOLD;
        pcb_pkg::PCB_SCAN: begin
          next_tmr = tmr + 16'h0001;
          if (tmr == SLOT - 16'h0001) begin
            next_tmr = '0;
            if (next_ch(cfg.chans, channel) != 3'h7) begin
              next_channel = next_ch(cfg.chans, channel);
            end else if (cfg.mode == pcb_pkg::PCB_RR_TEST && test_turn) begin
              // Self test on alternate cycles only
              next_state = pcb_pkg::PCB_T_LOW;
            end else begin
              loop_done = 1'b1;
              next_test_turn = !test_turn && cfg.mode == pcb_pkg::PCB_RR_TEST;
              next_channel = first_ch(cfg.chans);
            end
          end
        end
        pcb_pkg::PCB_T_LOW: begin
          next_tmr = tmr + 16'h0001;
          if (tmr == SLOT - 16'h0001) begin
            next_tmr = '0;
            next_hi_low_seen = hi_s;
            next_lo_low_seen = lo_s;
            next_state = pcb_pkg::PCB_T_HIGH;
          end
        end
        pcb_pkg::PCB_T_HIGH: begin
          next_tmr = tmr + 16'h0001;
          if (tmr == SLOT - 16'h0001) begin
            next_tmr = '0;
            next_state = pcb_pkg::PCB_JUDGE;
          end
        end
        pcb_pkg::PCB_JUDGE: begin
          // Output must change between the two DAC steps
          high_fail = (hi_low_seen == hi_s);
          low_fail = (lo_low_seen == lo_s);
          loop_done = 1'b1; // Cycle end includes the test slot
          next_test_turn = 1'b0;
          next_channel = first_ch(cfg.chans);
          next_state = pcb_pkg::PCB_SCAN;
        end
        default: next_state = pcb_pkg::PCB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      state <= pcb_pkg::PCB_IDLE;
      en_d <= 1'b0;
      tmr <= '0;
      channel <= 3'h0;
      test_turn <= 1'b0;
      hi_low_seen <= 1'b0;
      lo_low_seen <= 1'b0;
    end else begin
      cfg <= next_cfg;
      state <= next_state;
      en_d <= enable;
      tmr <= next_tmr;
      channel <= next_channel;
      test_turn <= next_test_turn;
      hi_low_seen <= next_hi_low_seen;
      lo_low_seen <= next_lo_low_seen;
    end
  end
endmodule // pcb_group
`default_nettype wire

// file: pcb_params.svh
// Constants for the protector comparator self-test controller.
// Assumes inclusion by bare name from the design modules.
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

// Register offsets (byte addresses on the plain register port)
`define PCB_DIAG_ONE_ADDR 8'h00
`define PCB_CTRL_TWO_ADDR 8'h04
`define PCB_VCH_EN_ADDR 8'h08
`define PCB_TCH_EN_ADDR 8'h0C
`define PCB_AUX_TWO_ADDR 8'h10
`define PCB_VFLT_ADDR 8'h14
`define PCB_TFLT_ADDR 8'h18
`define PCB_SYSF3_ADDR 8'h1C
`define PCB_LOOP_ADDR 8'h20
`define PCB_IRQ_ST_ADDR 8'h24
`define PCB_IRQ_MSK_ADDR 8'h28
`define PCB_STATE_ADDR 8'h2C
`define PCB_THR_ADDR 8'h30

// Field positions
`define PCB_VMODE_LSB 0
`define PCB_TMODE_LSB 2
`define PCB_VEN_BIT 0
`define PCB_TEN_BIT 1
`define PCB_THERMISTOR_REFERENCE_BIT 2
`define PCB_OVDAC_BIT 0
`define PCB_UVDAC_BIT 1
`define PCB_OTDAC_BIT 2
`define PCB_UTDAC_BIT 3

// Reset values
`define PCB_MODE_RST 2'h0
`define PCB_CH_RST 6'h00
`define PCB_THR_RST 8'h80

// Diagnostic DAC step of two LSB around the threshold
`define PCB_DIAG_STEP 8'h02

// Timing
`define PCB_CLK_NS 10
`define PCB_SLOT_NS 1000
`define PCB_DG_NS 200
`define PCB_SLOT_CYC (`PCB_SLOT_NS / `PCB_CLK_NS)
`define PCB_DG_CYC ((`PCB_DG_NS + `PCB_CLK_NS - 1) / `PCB_CLK_NS)

`endif

// file: pcb_pkg.sv
// Types for the protector comparator self-test controller.
// Assumes pcb_params.svh is available on the include path.
`default_nettype none
package pcb_pkg;

  typedef enum logic [1:0] {
    PCB_RR_TEST = 2'h0,
    PCB_RR_PLAIN = 2'h1,
    PCB_SINGLE_A = 2'h2,
    PCB_SINGLE_B = 2'h3
  } pcb_mode_t;

  // Scan sequencer states, Gray along scan, test low, test high, judge
  typedef enum logic [2:0] {
    PCB_IDLE = 3'h0,
    PCB_SCAN = 3'h1,
    PCB_T_LOW = 3'h3,
    PCB_T_HIGH = 3'h2,
    PCB_JUDGE = 3'h6,
    PCB_HOLD = 3'h7
  } pcb_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcb_req_t;

  // Latched group configuration
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] chans;
    logic dac_meas;
  } pcb_cfg_t;

  // Analog comparator pair of one group
  typedef struct packed {
    logic high_trip;
    logic low_trip;
  } pcb_cmp_t;

endpackage
`default_nettype wire
